// ### logic/anr_map.svh
// Offsets, field positions, advertisement reset value and write mask of the auto-negotiation registers
`ifndef ANR_MAP_SVH
`define ANR_MAP_SVH

// Register addresses on the management port
`define ANR_ADDR_ADVERT 5'h04
`define ANR_ADDR_PARTNER 5'h05
`define ANR_ADDR_EXPAND 5'h06

// Advertisement layout and reset value
`define ANR_ADV_RESET 16'h01E1
`define ANR_ADV_WMASK 16'hA5E0
`define ANR_ADV_SELECTOR 5'h01
`define ANR_ADV_T4_BIT 9

// Expansion field positions
`define ANR_EXP_PDF_BIT 4
`define ANR_EXP_PARTNER_NP_BIT 3
`define ANR_EXP_NPA_BIT 2
`define ANR_EXP_PGR_BIT 1
`define ANR_EXP_PARTNER_AN_BIT 0

// Partner word next-page position
`define ANR_PARTNER_NP_BIT 15

`endif

// ### logic/anr_pkg.sv
// Types shared by the auto-negotiation register block
package anr_pkg;

  // Exchange phase seen by the arbitration side
  typedef enum logic [1:0]
  {
    ANR_IDLE = 2'b00,
    ANR_EXCH = 2'b01,
    ANR_DONE = 2'b10
  } anr_phase_t;

  // Arbitration-side state
  typedef struct packed
  {
    anr_phase_t phase;
    logic [15:0] tx_word;
    logic [15:0] partner_word;
    logic partner_able;
    logic page_evt;
    logic complete;
  } anr_arb_state_t;

  // Register-side state
  typedef struct packed
  {
    logic [15:0] adv;
    logic pd_fault;
    logic page_rx;
    logic [15:0] rdata;
    logic rvalid;
    logic [15:0] tx_word;
    logic complete;
  } anr_reg_state_t;

endpackage

// ### logic/anr_neg_if.sv
// Carrier between the register side and the arbitration side
`timescale 1ns/1ps
interface anr_neg_if;
  logic start;
  logic restart;
  logic rx_valid;
  logic [15:0] rx_word;
  logic partner_an_able;
  logic done;
  logic [15:0] adv;
  logic [15:0] tx_word;
  logic [15:0] partner_word;
  logic partner_able;
  logic page_evt;
  logic complete;

  modport regs
  (
    output start, restart, rx_valid, rx_word, partner_an_able, done, adv,
    input tx_word, partner_word, partner_able, page_evt, complete
  );

  modport arb
  (
    input start, restart, rx_valid, rx_word, partner_an_able, done, adv,
    output tx_word, partner_word, partner_able, page_evt, complete
  );
endinterface

// ### logic/anr_arb_side.sv
// Arbitration-facing words: transmitted base word and received partner word
`timescale 1ns/1ps
`include "anr_map.svh"
module anr_arb_side
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link to the register side
  anr_neg_if.arb neg
);

  anr_pkg::anr_arb_state_t s_q;
  anr_pkg::anr_arb_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.page_evt = 1'b0;
    if (neg.restart)
    begin
      // Restart drops everything learned from the partner
      s_d.phase = anr_pkg::ANR_IDLE;
      s_d.partner_word = 16'h0000;
      s_d.partner_able = 1'b0;
      s_d.complete = 1'b0;
    end
    else
    begin
      case (s_q.phase)
        anr_pkg::ANR_IDLE:
        begin
          if (neg.start)
          begin
            // Snapshot of advert, pause and fault bits carried as is
            s_d.tx_word = neg.adv;
            s_d.phase = anr_pkg::ANR_EXCH;
          end
        end
        anr_pkg::ANR_EXCH:
        begin
          if (neg.done)
          begin
            s_d.phase = anr_pkg::ANR_DONE;
            s_d.complete = 1'b1;
          end
        end
        anr_pkg::ANR_DONE:
        begin
          if (neg.start)
          begin
            s_d.tx_word = neg.adv;
            s_d.phase = anr_pkg::ANR_EXCH;
            s_d.complete = 1'b0;
          end
        end
        default:
        begin
          s_d.phase = anr_pkg::ANR_IDLE;
        end
      endcase
      if (neg.rx_valid)
      begin
        // Partner word copied whole, no action on its flags
        s_d.partner_word = neg.rx_word;
        s_d.page_evt = 1'b1;
        s_d.partner_able = 1'b1;
      end
      if (neg.partner_an_able)
      begin
        s_d.partner_able = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign neg.tx_word = s_q.tx_word;
  assign neg.partner_word = s_q.partner_word;
  assign neg.partner_able = s_q.partner_able;
  assign neg.page_evt = s_q.page_evt;
  assign neg.complete = s_q.complete;

endmodule

// ### logic/anr_regs.sv
// Auto-negotiation advertisement, partner-ability and expansion registers
`timescale 1ns/1ps
`include "anr_map.svh"
module anr_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Management register port
  input wire logic [4:0] mg_addr,
  input wire logic mg_wr,
  input wire logic mg_rd,
  input wire logic [15:0] mg_wdata,
  output logic [15:0] mg_rdata,
  output logic mg_rvalid,
  // Arbitration events from the line side
  input wire logic an_start,
  input wire logic an_restart,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic partner_an_able,
  input wire logic pd_fault,
  input wire logic an_done,
  // Arbitration results
  output logic [15:0] tx_word,
  output logic an_complete
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Visible advertisement word from stored writable bits
  function automatic logic [15:0] adv_view(input logic [15:0] stored);
    logic [15:0] v;
    v = stored & `ANR_ADV_WMASK;
    v[`ANR_ADV_T4_BIT] = 1'b0;
    v[4:0] = `ANR_ADV_SELECTOR;
    return v;
  endfunction

  // Expansion word from flags and partner word
  function automatic logic [15:0] exp_view
  (
    input logic pdf,
    input logic pgr,
    input logic [15:0] partner,
    input logic able
  );
    logic [15:0] v;
    v = 16'h0000;
    v[`ANR_EXP_PDF_BIT] = pdf;
    v[`ANR_EXP_PARTNER_NP_BIT] = partner[`ANR_PARTNER_NP_BIT];
    v[`ANR_EXP_NPA_BIT] = 1'b1;
    v[`ANR_EXP_PGR_BIT] = pgr;
    v[`ANR_EXP_PARTNER_AN_BIT] = able;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration side

  anr_neg_if neg ();

  anr_pkg::anr_reg_state_t r_q;
  anr_pkg::anr_reg_state_t r_d;

  // Line events are on this clock, passed as they come
  assign neg.start = an_start;
  assign neg.restart = an_restart;
  assign neg.rx_valid = rx_word_valid;
  assign neg.rx_word = rx_word;
  assign neg.partner_an_able = partner_an_able;
  assign neg.done = an_done;
  assign neg.adv = adv_view(r_q.adv);

  anr_arb_side u_arb
  (
    .clk(clk),
    .reset(reset),
    .neg(neg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register next state
  always_comb
  begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    // Arbitration results copied out through the register state
    r_d.tx_word = neg.tx_word;
    r_d.complete = neg.complete;
    // Only writable advert bits are kept; others ignore writes
    if (mg_wr && (mg_addr == `ANR_ADDR_ADVERT))
    begin
      r_d.adv = mg_wdata & `ANR_ADV_WMASK;
    end
    // Read answer one cycle later, unmapped reads zero
    if (mg_rd)
    begin
      r_d.rvalid = 1'b1;
      case (mg_addr)
        `ANR_ADDR_ADVERT:
        begin
          r_d.rdata = adv_view(r_q.adv);
        end
        `ANR_ADDR_PARTNER:
        begin
          r_d.rdata = neg.partner_word;
        end
        `ANR_ADDR_EXPAND:
        begin
          r_d.rdata = exp_view(r_q.pd_fault, r_q.page_rx,
                               neg.partner_word, neg.partner_able);
          // Latched flags clear on read
          r_d.pd_fault = 1'b0;
          r_d.page_rx = 1'b0;
        end
        default:
        begin
          r_d.rdata = 16'h0000;
        end
      endcase
    end
    // New events win over a clear in the same cycle
    if (pd_fault)
    begin
      r_d.pd_fault = 1'b1;
    end
    if (neg.page_evt)
    begin
      r_d.page_rx = 1'b1;
    end
  end

  // Register state
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      r_q.adv <= `ANR_ADV_RESET & `ANR_ADV_WMASK;
      r_q.pd_fault <= 1'b0;
      r_q.page_rx <= 1'b0;
      r_q.rdata <= 16'h0000;
      r_q.rvalid <= 1'b0;
      r_q.tx_word <= 16'h0000;
      r_q.complete <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register
  assign mg_rdata = r_q.rdata;
  assign mg_rvalid = r_q.rvalid;
  assign tx_word = r_q.tx_word;
  assign an_complete = r_q.complete;

endmodule

// ### verif/anr_regs_chk.sv
// Port assertions for the auto-negotiation register block
`timescale 1ns/1ps
module anr_regs_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Management port
  input wire logic [4:0] mg_addr,
  input wire logic mg_rd,
  input wire logic [15:0] mg_rdata,
  input wire logic mg_rvalid,
  // Line side
  input wire logic an_start,
  input wire logic an_restart,
  input wire logic rx_word_valid,
  input wire logic pd_fault,
  input wire logic an_done,
  input wire logic [15:0] tx_word,
  input wire logic an_complete
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Read strobes per register
  logic rd_adv;
  logic rd_partner;
  logic rd_exp;
  assign rd_adv = mg_rd && mg_addr == 5'h04;
  assign rd_partner = mg_rd && mg_addr == 5'h05;
  assign rd_exp = mg_rd && mg_addr == 5'h06;
  //////////////////////////////////////////////////////////////////////////
  property p_rvalid; mg_rd |=> mg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read late");
  property p_t4; rd_adv |=> !mg_rdata[9]; endproperty
  a_t4: assert property (p_t4) else $error("four-pair bit set");
  property p_sel; rd_adv |=> mg_rdata[4:0] == 5'h01; endproperty
  a_sel: assert property (p_sel) else $error("selector wrong");
  property p_npa; rd_exp |=> mg_rdata[2]; endproperty
  a_npa: assert property (p_npa) else $error("next-page able low");
  property p_tx;
    an_start |-> ##2 tx_word[4:0] == 5'h01 && !tx_word[9];
  endproperty
  a_tx: assert property (p_tx) else $error("sent word fields wrong");
  property p_comp; $rose(an_complete) |-> $past(an_done, 2); endproperty
  a_comp: assert property (p_comp) else $error("early complete");
  property p_rst; an_restart |-> ##2 !an_complete; endproperty
  a_rst: assert property (p_rst) else $error("complete held");
  property p_ptnclr;
    an_restart ##1 !rx_word_valid ##1 rd_partner |=> mg_rdata == 16'h0000;
  endproperty
  a_ptnclr: assert property (p_ptnclr) else $error("partner kept");
  property p_pdf; pd_fault ##1 !mg_rd ##1 rd_exp |=> mg_rdata[4]; endproperty
  a_pdf: assert property (p_pdf) else $error("fault not latched");
  // Main scenarios reached
  c_comp: cover property ($rose(an_complete));
  c_pdf: cover property (pd_fault ##2 rd_exp);
  c_rst: cover property (an_restart ##2 rd_partner);
endmodule
bind anr_regs anr_regs_chk u_anr_regs_chk (.clk(clk), .reset(reset),
  .mg_addr(mg_addr), .mg_rd(mg_rd), .mg_rdata(mg_rdata),
  .mg_rvalid(mg_rvalid), .an_start(an_start), .an_restart(an_restart),
  .rx_word_valid(rx_word_valid), .pd_fault(pd_fault), .an_done(an_done),
  .tx_word(tx_word), .an_complete(an_complete));

// ### verif/anr_lp_model.sv
// Behavioural link partner and arbitration events on the line side
`timescale 1ns/1ps
module anr_partner_model
(
  // Clock
  input wire logic clk,
  // Line-side events
  output logic an_start,
  output logic an_restart,
  output logic rx_word_valid,
  output logic [15:0] rx_word,
  output logic partner_an_able,
  output logic pd_fault,
  output logic an_done
);
  // Quiet line at time zero
  initial
  begin
    {an_start, an_restart, rx_word_valid, partner_an_able} = 4'h0;
    {pd_fault, an_done} = 2'h0;
    rx_word = 16'h0000;
  end
  // Base page exchange, then finish
  task automatic link(input logic [15:0] w);
    @(posedge clk) an_start <= 1'b1;
    partner_an_able <= 1'b1;
    @(posedge clk) an_start <= 1'b0;
    partner_an_able <= 1'b0;
    repeat (2) @(posedge clk);
    rx_word_valid <= 1'b1;
    rx_word <= w;
    @(posedge clk) rx_word_valid <= 1'b0;
    rx_word <= ~w; // Stale word no longer shown
    an_done <= 1'b1;
    @(posedge clk) an_done <= 1'b0;
  endtask
  // Single parallel-detect fault
  task automatic fault();
    @(posedge clk) pd_fault <= 1'b1;
    @(posedge clk) pd_fault <= 1'b0;
  endtask
  // Negotiation restart
  task automatic restart();
    @(posedge clk) an_restart <= 1'b1;
    @(posedge clk) an_restart <= 1'b0;
  endtask
endmodule

// ### verif/test_autoneg_ability_registers.sv
// Self-checking bench for the auto-negotiation register block
`timescale 1ns/1ps
module test_autoneg_ability_registers;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] mg_addr = 5'h00;
  logic mg_wr = 1'b0;
  logic mg_rd = 1'b0;
  logic [15:0] mg_wdata = 16'h0000;
  logic [15:0] mg_rdata, rx_word, tx_word;
  logic mg_rvalid, an_start, an_restart, rx_word_valid;
  logic partner_an_able, pd_fault, an_done, an_complete;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  //////////////////////////////////////////////////////////////////////////
  // Design and line partner
  anr_regs u_anr_regs (.clk(clk), .reset(reset), .mg_addr(mg_addr),
    .mg_wr(mg_wr), .mg_rd(mg_rd), .mg_wdata(mg_wdata),
    .mg_rdata(mg_rdata), .mg_rvalid(mg_rvalid), .an_start(an_start),
    .an_restart(an_restart), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .partner_an_able(partner_an_able),
    .pd_fault(pd_fault), .an_done(an_done), .tx_word(tx_word),
    .an_complete(an_complete));
  anr_partner_model u_anr_partner_model (.clk(clk), .an_start(an_start),
    .an_restart(an_restart), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .partner_an_able(partner_an_able),
    .pd_fault(pd_fault), .an_done(an_done));
  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Compare and bus tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) mg_wr <= 1'b1;
    mg_addr <= a;
    mg_wdata <= d;
    @(posedge clk) mg_wr <= 1'b0;
    mg_wdata <= ~d;
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk) mg_rd <= 1'b1;
    mg_addr <= a;
    @(posedge clk) mg_rd <= 1'b0;
    #1;
    chk(mg_rvalid === 1'b1 ? mg_rdata : 16'hDEAD, e);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults();
    wr(5'h05, 16'hE7E1);
    wr(5'h06, 16'h001F);
    rc(5'h04, 16'h01E1);
    rc(5'h05, 16'h0000);
    rc(5'h06, 16'h0004);
    rc(5'h1F, 16'h0000);
  endtask
  task automatic t_advert();
    wr(5'h04, 16'hA5E1);
    rc(5'h04, 16'hA5E1);
    wr(5'h04, 16'h0001);
    rc(5'h04, 16'h0001);
    wr(5'h04, 16'h021E);
    rc(5'h04, 16'h0001);
  endtask
  task automatic t_exchange();
    wr(5'h04, 16'h2461);
    u_anr_partner_model.link(16'hE5E1);
    repeat (2) @(posedge clk);
    #1;
    chk(tx_word, 16'h2461);
    chk({15'h0000, an_complete}, 16'h0001);
    rc(5'h05, 16'hE5E1);
    rc(5'h06, 16'h000F);
    rc(5'h06, 16'h000D);
    u_anr_partner_model.fault();
    rc(5'h06, 16'h001D);
    rc(5'h06, 16'h000D);
    u_anr_partner_model.restart();
    rc(5'h05, 16'h0000);
    rc(5'h06, 16'h0004);
    chk({15'h0000, an_complete}, 16'h0000);
  endtask
  // Fault and expansion read on one edge: the fault survives the clear
  task automatic t_collide();
    fork
      u_anr_partner_model.fault();
      rc(5'h06, 16'h0004);
    join
    rc(5'h06, 16'h0014);
  endtask
  // New exchange from the finished phase takes a fresh snapshot
  task automatic t_rerun();
    u_anr_partner_model.link(16'h01E1);
    wr(5'h04, 16'h8181);
    u_anr_partner_model.link(16'h41E1);
    repeat (2) @(posedge clk);
    #1;
    chk(tx_word, 16'h8181);
    chk({15'h0000, an_complete}, 16'h0001);
    rc(5'h05, 16'h41E1);
    rc(5'h06, 16'h0007);
  endtask
  // Verdict
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_advert();
    t_exchange();
    t_collide();
    t_rerun();
    end_of_test();
  end
endmodule
